// ### hdl/prescaler_cfg.svh
/*
 * Register map, field positions and default divider width of the shared timer prescaler.
 * Assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
`ifndef PRESCALER_CFG_SVH
`define PRESCALER_CFG_SVH

`define ADDR_GENERAL_TIMER_SYNC_CONTROL 4'h0
`define ADDR_TIMER_CLOCK_SELECT 4'h4
`define ADDR_PRESCALER_STATUS 4'h8

`define SYNC_HOLD_MODE_BIT 7
`define PRESCALER_RESET_STROBE_BIT 0

`define SELECT0_LSB 0
`define SELECT1_LSB 4

`define STATUS_COUNT_LSB 0
`define STATUS_PIN0_BIT 16
`define STATUS_PIN1_BIT 17

`define DIVIDER_WIDTH_DEFAULT 10

`endif

// ### hdl/prescaler_pkg.sv
/*
 * Types shared by the prescaler design files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package prescaler_pkg;

    // encoding follows the per-timer clock-select field, 0 through 7
    typedef enum logic [2:0] {
        SEL_STOP,
        SEL_DIRECT,
        SEL_DIV8,
        SEL_DIV64,
        SEL_DIV256,
        SEL_DIV1024,
        SEL_EXT_FALL,
        SEL_EXT_RISE
    } timer_clock_select_t;

endpackage

// ### hdl/prescaler_divider.sv
/*
 * Free-running shared divider producing one-cycle tap enables at /8, /64, /256, /1024.
 * Assumes a synchronous active-high reset and a divider reset from the control register.
 */
`timescale 1ns/1ns
`include "prescaler_cfg.svh"

module prescaler_divider #(
    parameter int WIDTH = `DIVIDER_WIDTH_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic divider_reset_i,
    output logic [WIDTH-1:0] count_o,
    output logic [3:0] tap_o
);

    initial begin
        if (WIDTH < 10) begin
            $error("divider too narrow for the /1024 tap");
        end
    end

    // counts regardless of any clock select; only rst_i or the reset strobe stops it
    always_ff @(posedge clk_i) begin // see (RL3)
        if (rst_i || divider_reset_i) begin
            count_o <= '0; // see (RL19)
        end else begin
            count_o <= count_o + 1'b1;
        end
    end

    // a tap fires on the last cycle of its period, so after a reset all taps line up
    always_comb begin // see (RL2)
        tap_o[0] = (count_o[2:0] == 3'h7) && !divider_reset_i;
        tap_o[1] = (count_o[5:0] == 6'h3F) && !divider_reset_i;
        tap_o[2] = (count_o[7:0] == 8'hFF) && !divider_reset_i;
        tap_o[3] = (count_o[9:0] == 10'h3FF) && !divider_reset_i;
    end

    div_runs_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RL3)
        !divider_reset_i |=> count_o == $past(count_o) + 1'b1)
        else $error("divider did not advance");

    div_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RL19)
        divider_reset_i |=> count_o == '0)
        else $error("divider not cleared by reset strobe");

    tap8_period_a: assert property (@(posedge clk_i) // see (RL2)
        disable iff (rst_i || divider_reset_i)
        tap_o[0] |=> !tap_o[0] [*7] ##1 tap_o[0])
        else $error("divide-by-8 tap period wrong");

endmodule

// ### hdl/count_pin_sync.sv
/*
 * External count pin synchroniser and edge detector.
 * Assumes the pin is asynchronous to clk_i; a latch transparent while clk_i is high
 * feeds two flip-flops, and only the second flip-flop feeds the edge detector.
 */
`timescale 1ns/1ns

module count_pin_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ext_count_pin_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);

    logic pin_latch;
    logic sync_first;
    logic sync_second;
    logic sync_prev;

    // half-cycle front latch; it adds the half cycle in the 2.5 to 3.5 cycle delay
    always_latch begin // see (RL7)
        if (clk_i) begin
            pin_latch = ext_count_pin_i;
        end
    end

    always_ff @(posedge clk_i) begin // see (RL6)
        if (rst_i) begin
            sync_first <= 1'b0;
            sync_second <= 1'b0;
            sync_prev <= 1'b0;
        end else begin
            sync_first <= pin_latch;
            sync_second <= sync_first;
            sync_prev <= sync_second;
        end
    end

    assign level_o = sync_second;
    assign rise_o = sync_second && !sync_prev; // see (RL8)
    assign fall_o = !sync_second && sync_prev; // see (RL8)

    one_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RL8)
        (rise_o || fall_o) |=> !(rise_o || fall_o))
        else $error("edge detector gave more than one pulse per edge");

endmodule

// ### hdl/timer_prescaler.sv
/*
 * Shared timer prescaler with two clock-select fields, external count pins and the
 * general timer sync control register, reached over a classic Wishbone slave.
 * Assumes one 100 MHz clock clk_i, synchronous active-high reset, 32-bit bus.
 */
// The Wishbone slave port and the placing of the registers are this design's own decisions.
// Contract
// (RL1) select 1 counts every system clock
// (RL2) selects 2..5 pick taps /8 /64 /256 /1024
// (RL3) divider free-runs regardless of clock selects
// (RL4) one divider shared, selects independent per timer
// (RL5) first prescaled count within 1 to N+1
// (RL6) pin sampled each cycle, then edge detected
// (RL7) latch high phase, flops on rising edge
// (RL8) one pulse per rise (7) or fall (6)
// (RL9) pin edge reaches counter in 2.5-3.5 cycles
// (RL10) change pin select only while pin steady
// (RL11) external clock phases longer than one cycle
// (RL12) external pulses bypass the divider taps
// (RL13) hold mode keeps written prescaler reset value
// (RL14) clearing hold mode clears prescaler reset
// (RL15) prescaler reset self-clears unless hold mode
// (RL16) prescaler reset aligns counting with software
// (RL17) pin counts even when driven as output
// (RL18) select 0 gives no count enable
// (RL19) divider reset returns count to zero
`timescale 1ns/1ns
`include "prescaler_cfg.svh"

module timer_prescaler #(
    parameter int DIVIDER_WIDTH = `DIVIDER_WIDTH_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_count_pin0_i,
    input wire logic ext_count_pin1_i,
    output logic timer_count_pulse0_o,
    output logic timer_count_pulse1_o
);

    initial begin
        if (DIVIDER_WIDTH < 10 || DIVIDER_WIDTH > 16) begin
            $error("DIVIDER_WIDTH must be 10 to 16");
        end
    end

    logic sync_hold_mode;
    logic prescaler_reset_strobe;
    prescaler_pkg::timer_clock_select_t timer_clock_select0;
    prescaler_pkg::timer_clock_select_t timer_clock_select1;
    logic [DIVIDER_WIDTH-1:0] divider_count;
    logic [3:0] tap;
    logic pin0_level;
    logic pin0_rise;
    logic pin0_fall;
    logic pin1_level;
    logic pin1_rise;
    logic pin1_fall;
    logic bus_req;
    logic bus_write;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_write = bus_req && wb_we_i && wb_sel_i[0];

    // ack one cycle after the request, dropped in the cycle after it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // the write takes effect at the edge where ack is seen by the master
    logic write_now;
    assign write_now = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_cyc_i && wb_stb_i;

    logic ctrl_write;
    logic sel_write;
    assign ctrl_write = write_now && (wb_adr_i == `ADDR_GENERAL_TIMER_SYNC_CONTROL);
    assign sel_write = write_now && (wb_adr_i == `ADDR_TIMER_CLOCK_SELECT);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_hold_mode <= 1'b0;
        end else if (ctrl_write) begin
            sync_hold_mode <= wb_dat_i[`SYNC_HOLD_MODE_BIT];
        end
    end

    // a write loads the strobe; without hold mode it lives for exactly one cycle
    always_ff @(posedge clk_i) begin // see (RL16)
        if (rst_i) begin
            prescaler_reset_strobe <= 1'b0;
        end else if (ctrl_write) begin
            prescaler_reset_strobe <= wb_dat_i[`PRESCALER_RESET_STROBE_BIT]; // see (RL13)
        end else if (!sync_hold_mode) begin
            prescaler_reset_strobe <= 1'b0; // see (RL14) (RL15)
        end
    end

    // two independent select fields over one divider
    always_ff @(posedge clk_i) begin // see (RL4)
        if (rst_i) begin
            timer_clock_select0 <= prescaler_pkg::SEL_STOP;
            timer_clock_select1 <= prescaler_pkg::SEL_STOP;
        end else if (sel_write) begin
            timer_clock_select0 <= prescaler_pkg::timer_clock_select_t'(
                wb_dat_i[`SELECT0_LSB +: 3]);
            timer_clock_select1 <= prescaler_pkg::timer_clock_select_t'(
                wb_dat_i[`SELECT1_LSB +: 3]);
        end
    end

    // read data registered together with ack; unmapped words read as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req) begin
            wb_dat_o <= 32'h0000_0000;
            case (wb_adr_i)
                `ADDR_GENERAL_TIMER_SYNC_CONTROL: begin
                    wb_dat_o[`SYNC_HOLD_MODE_BIT] <= sync_hold_mode;
                    wb_dat_o[`PRESCALER_RESET_STROBE_BIT] <= prescaler_reset_strobe;
                end
                `ADDR_TIMER_CLOCK_SELECT: begin
                    wb_dat_o[`SELECT0_LSB +: 3] <= timer_clock_select0;
                    wb_dat_o[`SELECT1_LSB +: 3] <= timer_clock_select1;
                end
                `ADDR_PRESCALER_STATUS: begin
                    wb_dat_o[`STATUS_COUNT_LSB +: DIVIDER_WIDTH] <= divider_count;
                    wb_dat_o[`STATUS_PIN0_BIT] <= pin0_level;
                    wb_dat_o[`STATUS_PIN1_BIT] <= pin1_level;
                end
                default: begin
                    wb_dat_o <= 32'h0000_0000;
                end
            endcase
        end
    end

    prescaler_divider #(
        .WIDTH(DIVIDER_WIDTH)
    ) u_divider (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .divider_reset_i(prescaler_reset_strobe),
        .count_o(divider_count),
        .tap_o(tap)
    );

    // the pin is read as a level, so a pin driven as an output still counts
    count_pin_sync u_pin0 ( // see (RL17)
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ext_count_pin_i(ext_count_pin0_i),
        .level_o(pin0_level),
        .rise_o(pin0_rise),
        .fall_o(pin0_fall)
    );

    count_pin_sync u_pin1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ext_count_pin_i(ext_count_pin1_i),
        .level_o(pin1_level),
        .rise_o(pin1_rise),
        .fall_o(pin1_fall)
    );

    // shared mux; combinational so a selected tap reaches the timer in the same cycle
    function automatic logic pick_enable(
        input prescaler_pkg::timer_clock_select_t sel,
        input logic [3:0] taps,
        input logic rise,
        input logic fall
    );
        case (sel)
            prescaler_pkg::SEL_STOP: pick_enable = 1'b0; // see (RL18)
            prescaler_pkg::SEL_DIRECT: pick_enable = 1'b1; // see (RL1)
            prescaler_pkg::SEL_DIV8: pick_enable = taps[0]; // see (RL2)
            prescaler_pkg::SEL_DIV64: pick_enable = taps[1];
            prescaler_pkg::SEL_DIV256: pick_enable = taps[2];
            prescaler_pkg::SEL_DIV1024: pick_enable = taps[3];
            prescaler_pkg::SEL_EXT_FALL: pick_enable = fall; // see (RL8) (RL12)
            prescaler_pkg::SEL_EXT_RISE: pick_enable = rise;
            default: pick_enable = 1'b0;
        endcase
    endfunction

    // a select change while the pin moves may give one false pulse; software avoids it
    assign timer_count_pulse0_o = pick_enable(timer_clock_select0, tap, // see (RL10)
        pin0_rise, pin0_fall);
    assign timer_count_pulse1_o = pick_enable(timer_clock_select1, tap,
        pin1_rise, pin1_fall);

    direct_rate_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RL1)
        timer_clock_select0 == prescaler_pkg::SEL_DIRECT |-> timer_count_pulse0_o)
        else $error("direct select missed a cycle");

    stop_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RL18)
        timer_clock_select1 == prescaler_pkg::SEL_STOP |-> !timer_count_pulse1_o)
        else $error("stopped timer got a count");

    first_count_a: assert property (@(posedge clk_i) // see (RL5)
        disable iff (rst_i || prescaler_reset_strobe)
        $changed(timer_clock_select0) && timer_clock_select0 == prescaler_pkg::SEL_DIV8
        |-> ##[0:8] timer_count_pulse0_o)
        else $error("first /8 count later than N+1");

    div64_rate_a: assert property (@(posedge clk_i) // see (RL2)
        disable iff (rst_i || prescaler_reset_strobe)
        timer_clock_select1 == prescaler_pkg::SEL_DIV64 && timer_count_pulse1_o
        && $stable(timer_clock_select1) [*1]
        |=> (!timer_count_pulse1_o || timer_clock_select1 != prescaler_pkg::SEL_DIV64) [*8])
        else $error("/64 tap fired too soon");

    ext_rise_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RL9)
        timer_clock_select0 == prescaler_pkg::SEL_EXT_RISE && $rose(pin0_level)
        |-> timer_count_pulse0_o)
        else $error("rising pin edge gave no count");

    ext_fall_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RL12)
        timer_clock_select1 == prescaler_pkg::SEL_EXT_FALL
        |-> timer_count_pulse1_o == $fell(pin1_level))
        else $error("falling edge count not direct");

    hold_keeps_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RL13)
        sync_hold_mode && prescaler_reset_strobe && !ctrl_write
        |=> prescaler_reset_strobe [*1])
        else $error("hold mode lost prescaler reset");

    hold_release_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RL14)
        ctrl_write && !wb_dat_i[`SYNC_HOLD_MODE_BIT]
        |=> !sync_hold_mode ##1 !prescaler_reset_strobe)
        else $error("leaving hold mode kept prescaler reset");

    strobe_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RL15)
        prescaler_reset_strobe && !sync_hold_mode && !ctrl_write
        |=> !prescaler_reset_strobe)
        else $error("prescaler reset did not self-clear");

    ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    div1024_seen_c: cover property (@(posedge clk_i) disable iff (rst_i)
        timer_clock_select0 == prescaler_pkg::SEL_DIV1024 && timer_count_pulse0_o);

    ext_rise_seen_c: cover property (@(posedge clk_i) disable iff (rst_i)
        timer_clock_select1 == prescaler_pkg::SEL_EXT_RISE && timer_count_pulse1_o);

    hold_seen_c: cover property (@(posedge clk_i) disable iff (rst_i)
        sync_hold_mode && prescaler_reset_strobe ##1 !sync_hold_mode);

endmodule

// ### verif/ext_clock_source.sv
/*
 * Model of two external clock sources, one on each count pin.
 * Assumes run_i is driven just after a rising clock edge; pins stand still while idle.
 */
`timescale 1ns/1ns

module ext_clock_source (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic [3:0] half0_i,
    input wire logic [3:0] half1_i,
    output logic [1:0] pin_o
);
    logic [3:0] age [2];

    initial begin
        pin_o = 2'h0;
        age[0] = 4'h0;
        age[1] = 4'h0;
    end

    // phases of four clocks or more stay inside the recommended rate
    always @(posedge clk_i) begin
        for (int i = 0; i < 2; i++) begin
            if (!run_i) begin
                age[i] <= 4'h0;
            end else if (age[i] + 4'h1 >= (i == 0 ? half0_i : half1_i)) begin
                pin_o[i] <= ~pin_o[i];
                age[i] <= 4'h0;
            end else begin
                age[i] <= age[i] + 4'h1;
            end
        end
    end
endmodule

// ### verif/timer_prescaler_bench.sv
/*
 * Self-checking bench of the shared timer prescaler.
 * Assumes the design's register map header and the external clock source model.
 */
`timescale 1ns/1ns
`include "prescaler_cfg.svh"

module timer_prescaler_bench;
    localparam logic [3:0] a_ctl = `ADDR_GENERAL_TIMER_SYNC_CONTROL;
    localparam logic [3:0] a_sel = `ADDR_TIMER_CLOCK_SELECT;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, p0, p1, rd_pending = 1'b0, run = 1'b0, ext = 1'b0;
    logic [1:0] pin;
    logic [3:0] half0 = 4'h4;
    logic [3:0] half1 = 4'h5;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] cnt0 = 32'h0, cnt1 = 32'h0, rise0 = 32'h0, fall1 = 32'h0, s0, s1, r0, f1;
    logic [31:0] dv [4] = '{32'h8, 32'h40, 32'h100, 32'h400};
    logic last0 = 1'b0, last1 = 1'b0;
    int error_cnt = 0;
    int n_tests = 0;
    int seed = 99;
    int age = 0;
    int lat_lo = 99;
    int lat_hi = 0;
    int n;

    timer_prescaler timer_prescaler_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_count_pin0_i(pin[0]),
        .ext_count_pin1_i(pin[1]), .timer_count_pulse0_o(p0), .timer_count_pulse1_o(p1)
    );

    ext_clock_source ext_clock_source_inst (
        .clk_i(clk_i), .run_i(run), .half0_i(half0), .half1_i(half1), .pin_o(pin)
    );

    always #5 clk_i = ~clk_i;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // outputs are settled at the falling edge, so all watching happens there
    always @(negedge clk_i) begin
        cnt0 += 32'(p0 === 1'b1);
        cnt1 += 32'(p1 === 1'b1);
        rise0 += 32'(pin[0] && !last0);
        fall1 += 32'(!pin[1] && last1);
        age = (pin[0] !== last0) ? 1 : age + 1;
        last0 = pin[0];
        last1 = pin[1];
        if (ext && p0 === 1'b1) begin
            lat_lo = (age < lat_lo) ? age : lat_lo;
            lat_hi = (age > lat_hi) ? age : lat_hi;
        end
        if (rd_pending && wb_ack_o === 1'b1) begin
            check(wb_dat_o & msk_q.pop_front(), exp_q.pop_front());
        end
    end

    task automatic wb_cycle(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        rd_pending <= !we;
        @(negedge clk_i);
        while (wb_ack_o !== 1'b1) begin
            @(negedge clk_i);
        end
        @(posedge clk_i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        rd_pending <= 1'b0;
    endtask

    task automatic wb_read(input logic [3:0] adr, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        wb_cycle(1'b0, adr, 32'h0);
    endtask

    task automatic count_win(input int w, input logic [31:0] e0, input logic [31:0] e1);
        s0 = cnt0;
        s1 = cnt1;
        repeat (w) @(posedge clk_i);
        check(cnt0 - s0, e0);
        check(cnt1 - s1, e1);
    endtask

    // counts rising edges until the next timer 0 pulse has been seen
    task automatic first_pulse(input int lo, input int hi);
        n = 0;
        s0 = cnt0;
        while (cnt0 == s0 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        check(32'(n >= lo && n <= hi), 32'h1);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #300000;
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_read(a_ctl, 32'h0, 32'h81);
        wb_read(a_sel, 32'h0, 32'h77);
        wb_cycle(1'b1, 4'hC, 32'hFF);
        wb_read(4'hC, 32'h0, 32'hFFFFFFFF);
        count_win(64, 32'h0, 32'h0);
        wb_cycle(1'b1, a_sel, 32'h11);
        count_win(64, 32'h40, 32'h40);
        $display("test stop and direct done");
        for (int s = 2; s <= 5; s++) begin
            wb_cycle(1'b1, a_sel, 32'(s | ((7 - s) << 4)));
            count_win(2048, 32'h800 / dv[s - 2], 32'h800 / dv[5 - s]);
        end
        $display("test taps done");
        wb_cycle(1'b1, a_sel, 32'h0);
        repeat (1 + ($unsigned($random(seed)) % 8)) @(posedge clk_i);
        wb_cycle(1'b1, a_sel, 32'h22);
        first_pulse(1, 9);
        wb_cycle(1'b1, a_ctl, 32'h1);
        first_pulse(8, 10);
        wb_read(a_ctl, 32'h0, 32'h81);
        wb_cycle(1'b1, a_ctl, 32'h81);
        wb_read(a_ctl, 32'h81, 32'h81);
        count_win(128, 32'h0, 32'h0);
        wb_cycle(1'b1, a_ctl, 32'h0);
        wb_read(a_ctl, 32'h0, 32'h81);
        count_win(64, 32'h8, 32'h8);
        $display("test prescaler reset done");
        wb_cycle(1'b1, a_sel, 32'h67);
        ext = 1'b1;
        half0 <= 4'h4 + 4'($unsigned($random(seed)) % 4);
        half1 <= 4'h4 + 4'($unsigned($random(seed)) % 4);
        r0 = rise0;
        f1 = fall1;
        s0 = cnt0;
        s1 = cnt1;
        run <= 1'b1;
        repeat (400) @(posedge clk_i);
        run <= 1'b0;
        repeat (8) @(posedge clk_i);
        check(cnt0 - s0, rise0 - r0);
        check(cnt1 - s1, fall1 - f1);
        check(32'(lat_lo >= 2 && lat_hi <= 4), 32'h1);
        wb_read(`ADDR_PRESCALER_STATUS, {14'h0, pin, 16'h0}, 32'h30000);
        ext = 1'b0;
        $display("test external pins done");
        tally_and_finish();
    end
endmodule
